// ---- src/pcc_pkg.sv ----
// package: constants and carrier types for the port classification control block
package pcc_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned CLASS_PULSE_MS = 12;
  localparam int unsigned MARK_PAUSE_MS = 6;
  localparam int unsigned START_TIMER_MS = 60;
  localparam int unsigned CLASS_PULSE_CYC = CLK_HZ / 1000 * CLASS_PULSE_MS;
  localparam int unsigned MARK_PAUSE_CYC = CLK_HZ / 1000 * MARK_PAUSE_MS;
  localparam int unsigned START_TIMER_CYC = CLK_HZ / 1000 * START_TIMER_MS;
  localparam int unsigned CNT_W = 20;

  localparam logic [3:0] REG_PORT_MODE = 4'h0;
  localparam logic [3:0] REG_ENABLES = 4'h1;
  localparam logic [3:0] REG_TYPE2_MODE = 4'h2;
  localparam logic [3:0] REG_COMMAND = 4'h3;
  localparam logic [3:0] REG_PORT_STATUS = 4'h4;
  localparam logic [3:0] REG_TYPE2_STATUS = 4'h5;
  localparam logic [3:0] REG_CUT = 4'h6;
  localparam logic [3:0] REG_LIMIT = 4'h7;
  localparam logic [3:0] REG_INT_STATUS = 4'h8;
  localparam logic [3:0] REG_INT_ENABLE = 4'h9;
  localparam logic [3:0] REG_INT_CLEAR = 4'hA;

  localparam int unsigned EN_DETECT_BIT = 0;
  localparam int unsigned EN_CLASS_BIT = 1;
  localparam int unsigned EN_LEGACY_BIT = 2;
  localparam int unsigned EN_HIGH_POWER_BIT = 3;
  localparam int unsigned CMD_DETECT_BIT = 0;
  localparam int unsigned CMD_CLASS_BIT = 1;
  localparam int unsigned CMD_ON_BIT = 2;
  localparam int unsigned CMD_OFF_BIT = 3;
  localparam int unsigned IRQ_DET_BIT = 0;
  localparam int unsigned IRQ_CLASS_BIT = 1;
  localparam int unsigned IRQ_ON_BIT = 2;
  localparam int unsigned IRQ_START_FAULT_BIT = 3;

  // threshold codes, 1 lsb = 1 mA
  localparam logic [11:0] CUT_CLASS1 = 12'h070;
  localparam logic [11:0] CUT_CLASS2 = 12'h0CE;
  localparam logic [11:0] CUT_CLASS3 = 12'h177;
  localparam logic [11:0] CUT_CLASS4 = 12'h27E;
  localparam logic [11:0] LIMIT_LOW = 12'h1A9;
  localparam logic [11:0] LIMIT_HIGH = 12'h352;
  localparam logic [11:0] CUT_RESET = CUT_CLASS3;

  typedef enum logic [1:0] {PCC_SHUTDOWN, PCC_MANUAL, PCC_SEMI, PCC_AUTO} pcc_mode_t;
  typedef enum logic [2:0] {
    DET_UNKNOWN, DET_SHORT, DET_CAP_HIGH, DET_LOW, DET_GOOD, DET_HIGH, DET_OPEN, DET_VOLT
  } pcc_det_t;

  typedef enum {
    ST_IDLE, ST_DETECT, ST_CLASS1, ST_MARK, ST_CLASS2, ST_INRUSH, ST_ON
  } pcc_state_t;

  typedef struct packed {
    logic [6:0] req;
    logic [3:0] wdata_unused;
  } pcc_dummy_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pcc_bus_t;

  // analog front end measurements
  typedef struct packed {
    logic det_done;
    pcc_det_t det_result;
    logic cap_legacy;
    logic [2:0] class_meas;
    logic over_inrush;
  } pcc_afe_t;

  typedef struct packed {
    logic det_run;
    logic class_probe;
    logic mark_probe;
    logic gate_on;
    logic inrush_limit;
    logic full_enhance;
  } pcc_drive_t;
endpackage : pcc_pkg

// ---- src/pcc_port.sv ----
// module: one port's detect, classify and inrush sequencer with register file
// Overview of operation
// - legacy acceptance off at reset, host enabled
// - five classes; class 0 acts as 3
// - classify after detect, or on manual command
// - probe for pulse time, store class
// - auto mode loads thresholds from class
// - class table for cut and limit
// - no classification if pin low, shutdown, disabled
// - class 4 twice: mark, pause, reclassify, flag
// - type 2 enable bit; class 0-3 skips second
// - auto: power unless class 4 then lower
// - result holds last pulse; flag marks second
// - thresholds writable while powered
// - powered as type 1 for link negotiation
// - turn on: gate ramp, inrush limit, timer
// - inrush lasts timer; full enhancement from second inrush cycle unless above inrush
// - still above inrush at expiry: off, fault
// - semi high power: bad detect gives fault
module pcc_port
  import pcc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic auto_pin,
  input pcc_pkg::pcc_bus_t bus,
  output logic [15:0] rdata,
  input pcc_pkg::pcc_afe_t afe,
  output pcc_pkg::pcc_drive_t drive,
  output logic [11:0] overcurrent_cut_threshold,
  output logic [11:0] current_limit_threshold,
  output logic irq
);
  typedef struct packed {
    logic auto_pin_s1;
    logic auto_pin_s2;
    logic auto_latched;
    logic latch_done;
    logic [1:0] latch_cnt;
    logic det_done_s1;
    logic det_done_s2;
    logic det_done_p;
    pcc_afe_t afe_s1;
    pcc_afe_t afe_s2;
    pcc_state_t state;
    logic [CNT_W-1:0] cnt;
    pcc_mode_t mode;
    logic [3:0] enables;
    logic type2_en;
    pcc_det_t det_status;
    logic [2:0] class_result;
    logic first_was_4;
    logic second_run;
    logic [11:0] cut;
    logic [11:0] limit;
    logic [3:0] int_status;
    logic [3:0] int_enable;
    logic [15:0] rdata;
    pcc_drive_t drive;
    logic irq;
  } pcc_regs_t;

  pcc_regs_t q, d;

  // class 0 carries no signature and is handled as class 3
  function automatic logic [2:0] class_eff(input logic [2:0] c);
    class_eff = (c == 3'h0) ? 3'h3 : c;
  endfunction : class_eff

  function automatic logic [11:0] cut_for(input logic [2:0] c);
    unique case (class_eff(c))
      3'h1: cut_for = CUT_CLASS1;
      3'h2: cut_for = CUT_CLASS2;
      3'h4: cut_for = CUT_CLASS4;
      default: cut_for = CUT_CLASS3;
    endcase
  endfunction : cut_for

  function automatic logic load(input logic [CNT_W-1:0] c);
    load = (c == '0);
  endfunction : load

  logic class_allowed;
  logic det_ok;
  logic [3:0] ev;
  logic [3:0] cmd;

  always_comb
  begin
    d = q;
    ev = 4'h0;
    cmd = 4'h0;
    // class logic disabled by strap, shutdown or enable bit
    class_allowed = q.auto_latched && (q.mode != PCC_SHUTDOWN)
                    && q.enables[EN_CLASS_BIT];
    det_ok = (q.afe_s2.det_result == DET_GOOD)
             || (q.enables[EN_LEGACY_BIT] && q.afe_s2.cap_legacy);
    d.auto_pin_s1 = auto_pin;
    d.auto_pin_s2 = q.auto_pin_s1;
    // strap taken once after reset release; later changes need a reset
    // wait until the second sync stage holds the pin, not its reset value
    if (!q.latch_done)
    begin
      if (q.latch_cnt == 2'h2)
      begin
        d.auto_latched = q.auto_pin_s2;
        d.latch_done = 1'b1;
      end
      else
        d.latch_cnt = q.latch_cnt + 2'h1;
    end
    d.afe_s1 = afe;
    d.afe_s2 = q.afe_s1;
    d.det_done_s1 = q.afe_s2.det_done;
    d.det_done_p = q.afe_s2.det_done && !q.det_done_s1;
    d.det_done_s2 = q.det_done_s1;
    d.rdata = 16'h0000;
    if (bus.wr)
    begin
      unique case (bus.addr)
        REG_PORT_MODE: d.mode = pcc_mode_t'(bus.wdata[1:0]);
        REG_ENABLES: d.enables = bus.wdata[3:0];
        REG_TYPE2_MODE: d.type2_en = bus.wdata[0];
        REG_COMMAND: cmd = bus.wdata[3:0];
        REG_CUT: d.cut = bus.wdata[11:0];
        REG_LIMIT: d.limit = bus.wdata[11:0];
        REG_INT_ENABLE: d.int_enable = bus.wdata[3:0];
        default: ;
      endcase
    end
    if (bus.rd)
    begin
      unique case (bus.addr)
        REG_PORT_MODE: d.rdata = {14'h0000, q.mode};
        REG_ENABLES: d.rdata = {12'h000, q.enables};
        REG_TYPE2_MODE: d.rdata = {15'h0000, q.type2_en};
        REG_PORT_STATUS: d.rdata = {9'h000, q.class_result, 1'b0, q.det_status};
        REG_TYPE2_STATUS: d.rdata = {15'h0000, q.second_run};
        REG_CUT: d.rdata = {4'h0, q.cut};
        REG_LIMIT: d.rdata = {4'h0, q.limit};
        REG_INT_STATUS: d.rdata = {12'h000, q.int_status};
        REG_INT_ENABLE: d.rdata = {12'h000, q.int_enable};
        default: d.rdata = 16'h0000;
      endcase
    end
    if (q.cnt != '0)
      d.cnt = q.cnt - 1'b1;
    unique case (q.state)
      ST_IDLE:
      begin
        if (q.mode == PCC_SHUTDOWN || (q.mode == PCC_AUTO && !q.auto_latched))
          d.state = ST_IDLE;
        else if (cmd[CMD_ON_BIT] && q.mode != PCC_AUTO)
        begin
          // semi mode with high power refuses to power a bad detect
          if (q.mode == PCC_SEMI && q.enables[EN_HIGH_POWER_BIT]
              && q.det_status != DET_GOOD)
            ev[IRQ_START_FAULT_BIT] = 1'b1;
          else
          begin
            d.state = ST_INRUSH;
            d.cnt = CNT_W'(START_TIMER_CYC);
          end
        end
        else if (cmd[CMD_CLASS_BIT] && q.mode == PCC_MANUAL && class_allowed)
        begin
          d.state = ST_CLASS1;
          d.cnt = CNT_W'(CLASS_PULSE_CYC);
        end
        else if (q.enables[EN_DETECT_BIT]
                 && (q.mode != PCC_MANUAL || cmd[CMD_DETECT_BIT]))
          d.state = ST_DETECT;
      end
      ST_DETECT:
      begin
        if (q.det_done_p)
        begin
          ev[IRQ_DET_BIT] = 1'b1;
          d.det_status = det_ok ? DET_GOOD : q.afe_s2.det_result;
          d.second_run = 1'b0;
          d.first_was_4 = 1'b0;
          if (det_ok && class_allowed && q.mode != PCC_MANUAL)
          begin
            d.state = ST_CLASS1;
            d.cnt = CNT_W'(CLASS_PULSE_CYC);
          end
          else if (det_ok && q.mode == PCC_AUTO)
          begin
            d.state = ST_INRUSH;
            d.cnt = CNT_W'(START_TIMER_CYC);
          end
          else
            d.state = ST_IDLE;
        end
      end
      ST_CLASS1, ST_CLASS2:
      begin
        if (load(q.cnt))
        begin
          ev[IRQ_CLASS_BIT] = 1'b1;
          d.class_result = q.afe_s2.class_meas;
          if (q.state == ST_CLASS1 && q.afe_s2.class_meas == 3'h4 && q.type2_en)
          begin
            d.first_was_4 = 1'b1;
            d.second_run = 1'b1;
            d.state = ST_MARK;
            d.cnt = CNT_W'(MARK_PAUSE_CYC);
          end
          else if (q.mode == PCC_AUTO)
          begin
            d.cut = cut_for(q.afe_s2.class_meas);
            d.limit = (class_eff(q.afe_s2.class_meas) == 3'h4) ? LIMIT_HIGH : LIMIT_LOW;
            // class 4 then lower is not a type 2 signature
            if (q.first_was_4 && q.afe_s2.class_meas != 3'h4)
              d.state = ST_DETECT;
            else
            begin
              d.state = ST_INRUSH;
              d.cnt = CNT_W'(START_TIMER_CYC);
            end
          end
          else
            d.state = ST_IDLE;
        end
      end
      ST_MARK:
      begin
        if (load(q.cnt))
        begin
          d.state = ST_CLASS2;
          d.cnt = CNT_W'(CLASS_PULSE_CYC);
        end
      end
      ST_INRUSH:
      begin
        if (cmd[CMD_OFF_BIT])
          d.state = ST_IDLE;
        else if (load(q.cnt))
        begin
          if (q.afe_s2.over_inrush)
          begin
            ev[IRQ_START_FAULT_BIT] = 1'b1;
            d.state = ST_IDLE;
          end
          else
          begin
            ev[IRQ_ON_BIT] = 1'b1;
            d.state = ST_ON;
          end
        end
      end
      ST_ON:
      begin
        if (cmd[CMD_OFF_BIT])
          d.state = ST_IDLE;
      end
    endcase
    // limit returns to the low level whenever the port turns off
    if (d.state == ST_IDLE && (q.state == ST_INRUSH || q.state == ST_ON))
      d.limit = LIMIT_LOW;
    d.drive.det_run = (d.state == ST_DETECT);
    d.drive.class_probe = (d.state == ST_CLASS1) || (d.state == ST_CLASS2);
    d.drive.mark_probe = (d.state == ST_MARK);
    d.drive.gate_on = (d.state == ST_INRUSH) || (d.state == ST_ON);
    d.drive.inrush_limit = (d.state == ST_INRUSH);
    d.drive.full_enhance = (d.state == ST_ON)
                           || (d.state == ST_INRUSH && q.state == ST_INRUSH
                               && !q.afe_s2.over_inrush);
    // a new event wins over a clear in the same cycle
    d.int_status = (q.int_status & ~((bus.wr && bus.addr == REG_INT_CLEAR)
                   ? bus.wdata[3:0] : 4'h0)) | ev;
    d.irq = |(d.int_status & d.int_enable);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.state <= ST_IDLE;
      q.mode <= PCC_SHUTDOWN;
      q.enables <= 4'h0;
      q.cut <= CUT_RESET;
      q.limit <= LIMIT_LOW;
      q.det_status <= DET_UNKNOWN;
    end
    else
      q <= d;
  end

  assign rdata = q.rdata;
  assign drive = q.drive;
  assign overcurrent_cut_threshold = q.cut;
  assign current_limit_threshold = q.limit;
  assign irq = q.irq;
endmodule : pcc_port

// ---- testbench/pcc_port_assertions.sv ----
// checker: timing relations between the sequencer drive outputs
module pcc_port_checker
  import pcc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input pcc_pkg::pcc_drive_t drive,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  pcc_drive_t d;
  assign d = drive;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  chk_probe_excl: assert property (!(d.class_probe && d.mark_probe))
    else $error("class and mark probe overlap");
  chk_class_unpowered: assert property (d.class_probe |-> !d.gate_on)
    else $error("class probe while powered");
  chk_inrush_cap: assert property (d.gate_on && !d.full_enhance |-> d.inrush_limit)
    else $error("gate on without inrush limit");
  chk_gate_start: assert property ($rose(d.gate_on) |-> d.inrush_limit && !d.full_enhance)
    else $error("turn on skipped inrush");
  chk_enhance_late: assert property ($rose(d.full_enhance) |-> d.gate_on && $past(d.inrush_limit))
    else $error("full enhance before inrush");
  chk_inrush_exit: assert property ($fell(d.inrush_limit) |-> d.full_enhance || !d.gate_on)
    else $error("inrush ended with gate half on");
  chk_class_no_det: assert property ($rose(d.class_probe) |-> !d.det_run && !d.mark_probe)
    else $error("class probe during detection");
  chk_mark_after: assert property ($rose(d.mark_probe) |-> $past(d.class_probe))
    else $error("mark without preceding class");
  cov_class: cover property ($rose(d.class_probe));
  cov_power: cover property ($rose(d.gate_on));
  cov_irq: cover property ($rose(irq));
endmodule : pcc_port_checker

bind pcc_port pcc_port_checker i_chk (
  .clock(clock), .nrst(nrst), .drive(drive), .irq(irq)
);

// ---- testbench/pcc_pd_model.sv ----
// partner model: a powered device answering detection and class probes
module pcc_pd_model
  import pcc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input pcc_pkg::pcc_drive_t drive,
  input pcc_pkg::pcc_det_t det_code,
  input wire logic [3:0] dly,
  output pcc_pkg::pcc_afe_t afe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= 4'h0;
      afe <= '0;
    end
    else
    begin
      cnt_q <= !drive.det_run ? 4'h0 : (cnt_q == dly) ? cnt_q : cnt_q + 4'h1;
      afe.det_done <= drive.det_run && (cnt_q == dly);
      // result only valid at the end; unknown otherwise so stale codes are not reused
      afe.det_result <= (drive.det_run && cnt_q == dly) ? det_code : DET_UNKNOWN;
      afe.cap_legacy <= (det_code == DET_CAP_HIGH);
      afe.class_meas <= drive.class_probe ? 3'h4 : 3'h0;
      afe.over_inrush <= 1'b0;
    end
  end
endmodule : pcc_pd_model

// ---- testbench/pcc_port_tb.sv ----
// testbench: directed and seeded random stimulus for the port sequencer
module pcc_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pcc_pkg::*;
  localparam logic [5:0] D_DET = 6'h20;
  localparam logic [5:0] D_CLS = 6'h10;
  localparam logic [5:0] D_GATE = 6'h04;
  localparam logic [5:0] D_INR = 6'h02;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic auto_pin = 1'b1;
  pcc_bus_t bus = '0;
  logic [15:0] rdata;
  pcc_afe_t afe;
  pcc_drive_t drive;
  logic [11:0] cut;
  logic [11:0] lim;
  logic irq;
  logic [5:0] dv;
  pcc_det_t det_code = DET_CAP_HIGH;
  logic [3:0] dly = 4'h2;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 32'h437ce527;
  logic [15:0] v;
  always #50 clock = ~clock;
  assign dv = drive;
  pcc_port i_dut (.clock(clock), .nrst(nrst), .auto_pin(auto_pin), .bus(bus), .rdata(rdata),
    .afe(afe), .drive(drive), .overcurrent_cut_threshold(cut),
    .current_limit_threshold(lim), .irq(irq));
  pcc_pd_model i_pd (.clock(clock), .nrst(nrst), .drive(drive), .det_code(det_code),
    .dly(dly), .afe(afe));
  function automatic pcc_det_t exp_det(input pcc_det_t r, input logic leg);
    return (leg && r == DET_CAP_HIGH) ? DET_GOOD : r;
  endfunction : exp_det
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] dat);
    @(posedge clock);
    bus <= '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clock);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1;
    chk(what, exp, rdata);
  endtask : rc
  // bounded poll at the falling edge, where registered outputs have settled
  task automatic wait_drv(input logic [5:0] m, input logic [5:0] val);
    int n;
    for (n = 0; n < 400 && (dv & m) !== val; n++)
      @(negedge clock);
    if ((dv & m) !== val)
    begin
      num_errors++;
      $display("BAD drive wait exp %h got %h", val, dv & m);
      close_out();
    end
  endtask : wait_drv
  task automatic quiet_class;
    v = 16'h0000;
    repeat (40)
    begin
      @(negedge clock);
      v = v | {10'h000, dv & D_CLS};
    end
    chk("class idle", 16'h0000, v);
  endtask : quiet_class
  task automatic det_cycle(input logic [15:0] en);
    dly <= 4'($random(seed));
    wr(REG_ENABLES, en);
    wr(REG_COMMAND, 16'h0001);
    wait_drv(D_DET, D_DET);
    wait_drv(D_DET, 6'h00);
    repeat (6) @(negedge clock);
    rc(REG_PORT_STATUS, 16'(exp_det(det_code, en[EN_LEGACY_BIT])), "det status");
  endtask : det_cycle
  initial
  begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(negedge clock);
    chk("cut", 16'h0177, {4'h0, cut});
    chk("lim", 16'h01A9, {4'h0, lim});
    rc(REG_ENABLES, 16'h0000, "enables");
    rc(4'hB, 16'h0000, "unmapped");
    wr(REG_PORT_MODE, 16'h0001);
    wr(REG_INT_ENABLE, 16'h0001);
    det_cycle(16'h0003);
    quiet_class();
    chk("irq set", 16'h0001, {15'h0000, irq});
    wr(REG_INT_ENABLE, 16'h0000);
    repeat (2) @(negedge clock);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(REG_INT_CLEAR, 16'h0001);
    rc(REG_INT_STATUS, 16'h0000, "int cleared");
    wr(REG_ENABLES, 16'h0008);
    wr(REG_PORT_MODE, 16'h0002);
    wr(REG_COMMAND, 16'h0004);
    repeat (4) @(negedge clock);
    rc(REG_INT_STATUS, 16'h0008, "start fault");
    chk("no power", 16'h0000, {10'h000, dv & D_GATE});
    wr(REG_PORT_MODE, 16'h0001);
    wr(REG_COMMAND, 16'h0004);
    wait_drv(D_GATE | D_INR, D_GATE | D_INR);
    repeat (4) @(negedge clock);
    chk("enhance", 16'h0001, {15'h0000, drive.full_enhance});
    repeat (3)
    begin
      v = 16'($random(seed)) & 16'h0FFF;
      wr(REG_CUT, v);
      wr(REG_LIMIT, v ^ 16'h0FFF);
      @(negedge clock);
      chk("cut live", v, {4'h0, cut});
      rc(REG_LIMIT, v ^ 16'h0FFF, "limit reg");
    end
    wr(REG_COMMAND, 16'h0008);
    wait_drv(D_GATE, 6'h00);
    det_cycle(16'h0007);
    det_code <= DET_GOOD;
    wr(REG_PORT_MODE, 16'h0000);
    wr(REG_ENABLES, 16'h0001);
    wr(REG_PORT_MODE, 16'h0002);
    wait_drv(D_DET, D_DET);
    wait_drv(D_DET, 6'h00);
    quiet_class();
    wr(REG_PORT_MODE, 16'h0000);
    wr(REG_ENABLES, 16'h0003);
    wr(REG_PORT_MODE, 16'h0002);
    wait_drv(D_DET, D_DET);
    wait_drv(D_CLS, D_CLS);
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(negedge clock);
    chk("drive idle", 16'h0000, {10'h000, dv});
    wr(REG_PORT_MODE, 16'h0001);
    wr(REG_ENABLES, 16'h0003);
    wr(REG_COMMAND, 16'h0002);
    wait_drv(D_CLS, D_CLS);
    close_out();
  end
  initial
  begin
    #(100 * 100000);
    num_errors++;
    close_out();
  end
endmodule : pcc_port_tb
